// [tmr_irq_defs.vh]
// Constants for the external interrupt flag and timer mode block.
// Assumes an APB slave with 32-bit data and registers on aligned words.
// Notes on behaviour
// - Set irq B flag on matching edge/level.
// - Irq B flag cleared by software, or by vectoring in edge mode.
// - Irq A flag cleared by software, or by vectoring in edge mode.
// - Mode register layout, all bits reset zero.
// - Gate set: timer B needs run and pin.
// - Count source one: count falling external edges.
`ifndef TMR_IRQ_DEFS_VH
`define TMR_IRQ_DEFS_VH
`define ADDR_TIMER_CONTROL 12'h000
`define ADDR_TIMER_MODE 12'h004
`define ADDR_POLARITY 12'h008
`define ADDR_STATUS 12'h00c
`define CTL_RUN_B 7
`define CTL_RUN_A 5
`define CTL_FLAG_B 3
`define CTL_TYPE_B 2
`define CTL_FLAG_A 1
`define CTL_TYPE_A 0
`define MODE_GATE_B 7
`define MODE_SRC_B 6
`define MODE_FIELD_B_HI 5
`define MODE_FIELD_B_LO 4
`define MODE_GATE_A 3
`define MODE_SRC_A 2
`define MODE_FIELD_A_HI 1
`define MODE_FIELD_A_LO 0
`define POL_A 0
`define POL_B 1
`define RESET_BYTE 8'h00
`define RESET_POL 2'h0
`define BYTE_MSB 7
`define DATA_LSB 0
`define STATUS_MSB 3
`define DATA_ZERO 32'h00000000
`define FIELD_ZERO 2'h0
`define PIN_IDLE 1'b1
`endif

// [pin_sync3.v]
// Three-stage synchroniser for one pin, with an agreed-change output.
// Assumes the pin is asynchronous to clk; ce freezes all stages.
`timescale 1ns/100ps
`include "tmr_irq_defs.vh"
module pin_sync3 (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire pinIn,
    output reg pinOut
);
    // Raw first stage, read only by the second stage.
    reg stage1;
    // Second and third stages; a change counts once both agree.
    reg stage2;
    reg stage3;

    // Shift chain and agreement filter.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Stages start at the idle level, so reset release shows no false edge.
            stage1 <= `PIN_IDLE;
            stage2 <= `PIN_IDLE;
            stage3 <= `PIN_IDLE;
            pinOut <= `PIN_IDLE;
        end else if (ce) begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            // Only an agreed level replaces the filtered output.
            if (stage2 == stage3) begin
                pinOut <= stage3;
            end
        end
    end
endmodule // pin_sync3

// [ext_irq_timer_mode.v]
// External interrupt flags, trigger selects and timer mode register over APB.
// Assumes async pins for interrupts and count inputs, and a CPU vector strobe.
`timescale 1ns/100ps
`include "tmr_irq_defs.vh"
module ext_irq_timer_mode (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire extIrqAInput,
    input wire extIrqBInput,
    input wire tmrACountPin,
    input wire tmrBCountPin,
    input wire vectorIrqA,
    input wire vectorIrqB,
    output reg extIrqAFlag,
    output reg extIrqBFlag,
    output reg tmrACountEnable,
    output reg tmrBCountEnable,
    output reg tmrACountTick,
    output reg tmrBCountTick,
    output reg [1:0] tmrAModeField,
    output reg [1:0] tmrBModeField
);
    // Mode register and the control bits kept here.
    reg [7:0] timerModeSelect;
    reg tmrARunBit;
    reg tmrBRunBit;
    reg extIrqATriggerType;
    reg extIrqBTriggerType;
    reg [1:0] polarity;
    // Filtered pin levels and their previous values.
    wire irqASync;
    wire irqBSync;
    wire cntASync;
    wire cntBSync;
    reg irqAPrev;
    reg irqBPrev;
    reg cntAPrev;
    reg cntBPrev;

    // Active level of an interrupt pin after polarity.
    function active;
        input level;
        input pol;
        begin
            active = level ^ ~pol;
        end
    endfunction

    // True when an address selects one of the four mapped words.
    function isMapped;
        input [11:0] addr;
        begin
            isMapped = (addr == `ADDR_TIMER_CONTROL) || (addr == `ADDR_TIMER_MODE) ||
                       (addr == `ADDR_POLARITY) || (addr == `ADDR_STATUS);
        end
    endfunction

    // Interrupt A pin filter.
    pin_sync3 syncIrqA (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pinIn(extIrqAInput),
        .pinOut(irqASync)
    );
    // Interrupt B pin filter.
    pin_sync3 syncIrqB (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pinIn(extIrqBInput),
        .pinOut(irqBSync)
    );
    // Timer A count pin filter.
    pin_sync3 syncCntA (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pinIn(tmrACountPin),
        .pinOut(cntASync)
    );
    // Timer B count pin filter.
    pin_sync3 syncCntB (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pinIn(tmrBCountPin),
        .pinOut(cntBSync)
    );

    // Bus always answers in the access cycle; unmapped addresses error.
    wire mapped = isMapped(paddr);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    // Writes land at the access edge; ce low refuses them without a wait state.
    wire wrEn = psel & penable & pwrite & ce;
    // Read data is captured in the setup cycle of a read.
    wire setupRd = psel & ~penable & ~pwrite;

    // Write strobe for one mapped word.
    function writeTo;
        input [11:0] addr;
        begin
            writeTo = wrEn & (paddr == addr);
        end
    endfunction

    wire wrCtl = writeTo(`ADDR_TIMER_CONTROL);
    wire wrMode = writeTo(`ADDR_TIMER_MODE);
    wire wrPol = writeTo(`ADDR_POLARITY);
    // Active events; edge mode sees the asserting edge, level mode the level.
    wire irqAActive = active(irqASync, polarity[`POL_A]);
    wire irqBActive = active(irqBSync, polarity[`POL_B]);
    wire irqAPrevActive = active(irqAPrev, polarity[`POL_A]);
    wire irqBPrevActive = active(irqBPrev, polarity[`POL_B]);
    wire eventA = extIrqATriggerType ? (irqAActive & ~irqAPrevActive) : irqAActive;
    wire eventB = extIrqBTriggerType ? (irqBActive & ~irqBPrevActive) : irqBActive;

    // Register writes, flag updates and timer enables.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timerModeSelect <= `RESET_BYTE;
            tmrARunBit <= 1'b0;
            tmrBRunBit <= 1'b0;
            extIrqATriggerType <= 1'b0;
            extIrqBTriggerType <= 1'b0;
            polarity <= `RESET_POL;
            extIrqAFlag <= 1'b0;
            extIrqBFlag <= 1'b0;
            // Previous levels match the idle pin, so no edge follows reset.
            irqAPrev <= `PIN_IDLE;
            irqBPrev <= `PIN_IDLE;
            cntAPrev <= `PIN_IDLE;
            cntBPrev <= `PIN_IDLE;
            tmrACountEnable <= 1'b0;
            tmrBCountEnable <= 1'b0;
            tmrACountTick <= 1'b0;
            tmrBCountTick <= 1'b0;
            tmrAModeField <= `FIELD_ZERO;
            tmrBModeField <= `FIELD_ZERO;
        end else if (ce) begin
            irqAPrev <= irqASync;
            irqBPrev <= irqBSync;
            cntAPrev <= cntASync;
            cntBPrev <= cntBSync;
            if (wrMode) begin
                timerModeSelect <= pwdata[`BYTE_MSB:`DATA_LSB];
            end
            if (wrPol) begin
                polarity <= pwdata[`POL_B:`POL_A];
            end
            if (wrCtl) begin
                tmrBRunBit <= pwdata[`CTL_RUN_B];
                tmrARunBit <= pwdata[`CTL_RUN_A];
                extIrqBTriggerType <= pwdata[`CTL_TYPE_B];
                extIrqATriggerType <= pwdata[`CTL_TYPE_A];
            end
            // irq B clear; a new event wins over any clear.
            if (eventB) begin
                extIrqBFlag <= 1'b1;
            end else if (wrCtl) begin
                extIrqBFlag <= pwdata[`CTL_FLAG_B];
            end else if (vectorIrqB && extIrqBTriggerType) begin
                extIrqBFlag <= 1'b0;
            end
            // irq A clear; the same precedence as irq B.
            if (eventA) begin
                extIrqAFlag <= 1'b1;
            end else if (wrCtl) begin
                extIrqAFlag <= pwdata[`CTL_FLAG_A];
            end else if (vectorIrqA && extIrqATriggerType) begin
                extIrqAFlag <= 1'b0;
            end
            tmrBCountEnable <= tmrBRunBit & (~timerModeSelect[`MODE_GATE_B] | irqBActive);
            tmrACountEnable <= tmrARunBit & (~timerModeSelect[`MODE_GATE_A] | irqAActive);
            // falling edge count; a tick only in counter mode.
            tmrBCountTick <= timerModeSelect[`MODE_SRC_B] & cntBPrev & ~cntBSync;
            tmrACountTick <= timerModeSelect[`MODE_SRC_A] & cntAPrev & ~cntASync;
            tmrBModeField <= timerModeSelect[`MODE_FIELD_B_HI:`MODE_FIELD_B_LO];
            tmrAModeField <= timerModeSelect[`MODE_FIELD_A_HI:`MODE_FIELD_A_LO];
        end
    end

    // Read word for one address; reserved bits and unmapped words read zero.
    function [31:0] readWord;
        input [11:0] addr;
        begin
            readWord = `DATA_ZERO;
            case (addr)
                `ADDR_TIMER_CONTROL: begin
                    readWord[`CTL_RUN_B] = tmrBRunBit;
                    readWord[`CTL_RUN_A] = tmrARunBit;
                    readWord[`CTL_FLAG_B] = extIrqBFlag;
                    readWord[`CTL_TYPE_B] = extIrqBTriggerType;
                    readWord[`CTL_FLAG_A] = extIrqAFlag;
                    readWord[`CTL_TYPE_A] = extIrqATriggerType;
                end
                `ADDR_TIMER_MODE: readWord[`BYTE_MSB:`DATA_LSB] = timerModeSelect;
                `ADDR_POLARITY: readWord[`POL_B:`POL_A] = polarity;
                `ADDR_STATUS: readWord[`STATUS_MSB:`DATA_LSB] = {cntBSync, cntASync, irqBSync, irqASync};
                default: readWord = `DATA_ZERO;
            endcase
        end
    endfunction

    // Read data register: loaded in the setup cycle, it stands for the whole
    // access cycle; the price is that a read shows the state one cycle early.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= `DATA_ZERO;
        end else if (ce) begin
            // Writes leave the last read word in place.
            if (setupRd) begin
                prdata <= readWord(paddr);
            end
        end
    end
endmodule // ext_irq_timer_mode

// [ext_irq_timer_mode_properties.sv]
// Port checker for the interrupt flag and timer mode block.
// Assumes it is bound to ext_irq_timer_mode on one clock domain.
`timescale 1ns/100ps
`include "tmr_irq_defs.vh"
module ext_irq_timer_mode_properties (
    input logic clk,
    input logic nrst,
    input logic ce,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic tmrACountTick,
    input logic tmrBCountTick,
    input logic [1:0] tmrAModeField,
    input logic [1:0] tmrBModeField
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // An access phase; pready is tied high, so it is also the completing edge.
    wire acc = psel && penable;
    chk_ready_always: assert property (pready) else $error("pready low");
    // Only the four aligned words are mapped; every other address errors.
    wire mapped = paddr == `ADDR_TIMER_CONTROL || paddr == `ADDR_TIMER_MODE ||
        paddr == `ADDR_POLARITY || paddr == `ADDR_STATUS;
    chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped access");
    chk_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    // The field outputs copy the register one edge after the write lands.
    chk_mode_b_write: assert property (acc && pwrite && ce && paddr == `ADDR_TIMER_MODE
        |=> ##1 tmrBModeField == $past(pwdata[5:4], 2)) else $error("mode field B wrong");
    chk_mode_a_write: assert property (acc && pwrite && ce && paddr == `ADDR_TIMER_MODE
        |=> ##1 tmrAModeField == $past(pwdata[1:0], 2)) else $error("mode field A wrong");
    chk_tick_b_pulse: assert property (tmrBCountTick |=> !tmrBCountTick)
        else $error("tick B too long");
    chk_tick_a_pulse: assert property (tmrACountTick |=> !tmrACountTick)
        else $error("tick A too long");
    cover property (tmrBCountTick);
    cover property (tmrACountTick);
    cover property (acc && pslverr);
    cover property (acc && pwrite && paddr == 12'h004);
endmodule // ext_irq_timer_mode_properties
bind ext_irq_timer_mode ext_irq_timer_mode_properties i_props (.clk(clk), .nrst(nrst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tmrACountTick(tmrACountTick),
    .tmrBCountTick(tmrBCountTick), .tmrAModeField(tmrAModeField), .tmrBModeField(tmrBModeField));

// [ext_pins_model.sv]
// Model of the pins and the CPU vector strobes around the block.
// Assumes active-low pins, so every pin idles high.
`timescale 1ns/100ps
module ext_pins_model (
    input logic clk,
    output logic irqA = 1'b1,
    output logic irqB = 1'b1,
    output logic cntA = 1'b1,
    output logic cntB = 1'b1,
    output logic vecA = 1'b0,
    output logic vecB = 1'b0
);
    // Moves one interrupt pin just after an edge.
    task setIrq(input logic b, input logic v);
        @(posedge clk);
        if (b) irqB <= v;
        else irqA <= v;
    endtask
    // Vector strobe lasts exactly one cycle, as the CPU gives it.
    task vector(input logic b);
        @(posedge clk);
        if (b) vecB <= 1'b1;
        else vecA <= 1'b1;
        @(posedge clk);
        vecA <= 1'b0;
        vecB <= 1'b0;
    endtask
    // Slow pulses so the synchroniser sees every falling edge.
    task cntPulses(input int n);
        repeat (n) begin
            @(posedge clk);
            {cntA, cntB} <= 2'b00;
            repeat (4) @(posedge clk);
            {cntA, cntB} <= 2'b11;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule // ext_pins_model

// [tb.sv]
// Testbench for the interrupt flag and timer mode block.
// Assumes pins and vector strobes come from ext_pins_model.
`timescale 1ns/100ps
`include "tmr_irq_defs.vh"
module tb;
    logic clk = 0, nrst = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, slvErr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, d;
    wire [31:0] prdata;
    wire pready, pslverr, irqA, irqB, cntA, cntB, vecA, vecB, flagA, flagB, enA, enB, tkA, tkB;
    wire [1:0] modeA, modeB;
    int err_count = 0, check_count = 0, ticksA = 0, ticksB = 0;
    always #5 clk = ~clk;
    // Ticks are counted off the edge, where they are settled.
    always @(negedge clk) begin
        if (tkA === 1'b1) ticksA++;
        if (tkB === 1'b1) ticksB++;
    end
    ext_irq_timer_mode i_ext_irq_timer_mode (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extIrqAInput(irqA), .extIrqBInput(irqB),
        .tmrACountPin(cntA), .tmrBCountPin(cntB), .vectorIrqA(vecA), .vectorIrqB(vecB),
        .extIrqAFlag(flagA), .extIrqBFlag(flagB), .tmrACountEnable(enA),
        .tmrBCountEnable(enB), .tmrACountTick(tkA), .tmrBCountTick(tkB),
        .tmrAModeField(modeA), .tmrBModeField(modeB));
    ext_pins_model i_ext_pins_model (.clk(clk), .irqA(irqA), .irqB(irqB), .cntA(cntA),
        .cntB(cntB), .vecA(vecA), .vecB(vecB));
    // One APB transfer; read data is taken at the edge that sees pready.
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        slvErr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task complete_run;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Sets a flag, vectors while the pin is still active, then clears by software.
    task irqCase(input logic b, input logic edgeMode);
        xfer(1, `ADDR_TIMER_CONTROL, {31'h0, edgeMode} << (b ? `CTL_TYPE_B : `CTL_TYPE_A));
        i_ext_pins_model.setIrq(b, 1'b0);
        repeat (8) @(posedge clk);
        cmp(b ? flagB : flagA, 1);
        i_ext_pins_model.vector(b);
        repeat (2) @(posedge clk);
        cmp(b ? flagB : flagA, !edgeMode);
        i_ext_pins_model.setIrq(b, 1'b1);
        repeat (8) @(posedge clk);
        xfer(1, `ADDR_TIMER_CONTROL, 0);
        repeat (2) @(posedge clk);
        cmp(b ? flagB : flagA, 0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        xfer(0, `ADDR_TIMER_MODE, 0);
        cmp(rd, 0);
        cmp({slvErr, flagB, flagA, enB, enA, tkB, tkA}, 0);
        xfer(0, `ADDR_STATUS, 0);
        cmp(rd, 32'hf);
        for (int i = 0; i < 2; i++) begin
            d = i ? 32'h5a : 32'ha5;
            xfer(1, `ADDR_TIMER_MODE, d);
            xfer(0, `ADDR_TIMER_MODE, 0);
            cmp(rd, d);
            cmp({modeB, modeA}, {d[5:4], d[1:0]});
        end
        @(posedge clk);
        ce <= 1'b0;
        xfer(1, `ADDR_TIMER_MODE, 32'h33);
        ce <= 1'b1;
        xfer(0, `ADDR_TIMER_MODE, 0);
        cmp(rd, 32'h5a);
        xfer(0, 12'h010, 0);
        cmp(rd, 0);
        cmp(slvErr, 1);
        for (int i = 0; i < 4; i++) irqCase(i[1], i[0]);
        xfer(1, `ADDR_TIMER_MODE, 32'h80);
        xfer(1, `ADDR_TIMER_CONTROL, 32'h80);
        repeat (8) @(posedge clk);
        cmp(enB, 0);
        i_ext_pins_model.setIrq(1, 1'b0);
        repeat (8) @(posedge clk);
        cmp(enB, 1);
        i_ext_pins_model.setIrq(1, 1'b1);
        xfer(1, `ADDR_TIMER_MODE, 0);
        repeat (8) @(posedge clk);
        cmp(enB, 1);
        xfer(1, `ADDR_TIMER_MODE, 32'h88);
        xfer(1, `ADDR_TIMER_CONTROL, 32'ha0);
        repeat (8) @(posedge clk);
        cmp({enB, enA}, 0);
        xfer(1, `ADDR_POLARITY, 32'h3);
        repeat (2) @(posedge clk);
        cmp({enB, enA}, 3);
        xfer(0, `ADDR_POLARITY, 0);
        cmp(rd, 3);
        xfer(1, `ADDR_POLARITY, 0);
        xfer(1, `ADDR_TIMER_MODE, 32'h44);
        i_ext_pins_model.cntPulses(3);
        cmp(ticksA + 100 * ticksB, 303);
        xfer(1, `ADDR_TIMER_MODE, 0);
        i_ext_pins_model.cntPulses(2);
        cmp(ticksA + 100 * ticksB, 303);
        complete_run;
    end
    initial begin
        #100000;
        err_count++;
        complete_run;
    end
endmodule // tb
